// file: verif/rbrd_host_model.sv
// Host bus master model that issues slave cycles into the decoder
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Host model
module rbrd_host_model (
  input  wire logic                        core_clk_i, // Device clock
  input  wire logic                        ack_i,      // Cycle claimed
  input  wire logic [rbrd_pkg::DATA_W-1:0] rdata_i,    // Read data
  output var  rbrd_pkg::rbrd_host_t        host_o      // Slave cycle out
);
  import rbrd_pkg::*;

  // Idle bus: deselected, no strobes
  initial host_o = '{sel_n: 1'b1, mem: 1'b0, rd: 1'b0, wr: 1'b0,
                     addr: '0, wdata: '0};

  // One strobe pulse, answer taken 1 ns after the taking edge.
  // Released lines carry the inverse so stale values never look valid.
  task automatic cyc(input logic sel_n, input logic mem, input logic rd,
                     input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, output logic ack,
                     output logic [DATA_W-1:0] q);
    begin
      @(posedge core_clk_i);
      #1;
      host_o = '{sel_n: sel_n, mem: mem, rd: rd, wr: wr, addr: a, wdata: d};
      @(posedge core_clk_i);
      #1;
      ack = ack_i;
      q = rdata_i;
      host_o = '{sel_n: 1'b1, mem: ~mem, rd: 1'b0, wr: 1'b0,
                 addr: ~a, wdata: ~d};
    end
  endtask : cyc
endmodule : rbrd_host_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking testbench for the register block relocation decoder
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Testbench top
module tb;
  import rbrd_pkg::*;

  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  rbrd_host_t host_i;
  logic [SIZE_W-1:0] gfx_size = GFX_FULL;
  logic [ADDR_W-1:0] eng_addr = '0;
  logic il = 1'b0;
  logic fp = 1'b0;
  rbrd_req_t req = '0;
  logic ack_o, reg_hit_o, host_gfx_o, word_mode_o, mem_space_o;
  logic relocated_o, eng_gfx_o, eng_sys_o;
  logic [DATA_W-1:0] rdata_o;
  logic [ADDR_W-1:0] pin_addr_o;
  rbrd_req_t req_o;
  rbrd_rate_t rate_o;
  int n_errors = 0;
  int checked = 0;
  // Reference state of the register block
  int reloc = 0;
  int ctrl = 0;
  bit placed = 0;
  int held_q[$];  // Held even byte: offset, then data
  logic [ADDR_W-1:0] a;

  always #2 core_clk_i = ~core_clk_i;

  rbrd_top u_rbrd_top (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .host_i(host_i), .gfx_size_i(gfx_size), .eng_addr_i(eng_addr),
    .interleave_i(il), .fast_page_i(fp), .req_i(req), .ack_o(ack_o),
    .rdata_o(rdata_o), .reg_hit_o(reg_hit_o), .host_gfx_o(host_gfx_o),
    .pin_addr_o(pin_addr_o), .word_mode_o(word_mode_o),
    .mem_space_o(mem_space_o), .relocated_o(relocated_o),
    .eng_gfx_o(eng_gfx_o), .eng_sys_o(eng_sys_o), .req_o(req_o),
    .rate_o(rate_o));

  rbrd_host_model u_rbrd_host_model (.core_clk_i(core_clk_i),
    .ack_i(ack_o), .rdata_i(rdata_o), .host_o(host_i));

  // ============================================================
  // Checking helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checked++;
      if (got !== exp)
      begin
        n_errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask : chk

  task conclude;
    begin
      $display("checks=%0d errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask : conclude

  // Block hit as the reference sees it, from relocation state
  function automatic bit hit_exp(input logic m, input logic [21:0] ad);
    if (!placed)
      return !m;
    if (m != reloc[0])
      return 0;
    return m ? (ad[21:7] == reloc[15:1]) : (ad[15:7] == reloc[9:1]);
  endfunction : hit_exp

  // A 16-bit commit into the reference registers
  task automatic commit(input int off, input int d);
    begin
      if (off == 0)
      begin
        reloc = d;
        placed = 1;
      end
      if (off == 2)
        ctrl = d & 16'h0010;
    end
  endtask : commit

  // One host cycle, compared against the reference at every result
  task automatic host(input logic sn, input logic m, input logic r,
                      input logic w, input logic [21:0] ad,
                      input logic [15:0] d);
    logic ack;
    logic [15:0] q;
    bit h;
    bit g;
    int v;
    int o;
    logic [21:0] pe;
    begin
      h = !sn && hit_exp(m, ad);
      g = !sn && m && !h && ({1'b0, ad} < gfx_size);
      pe = {reloc[15:1], ad[6:0]};
      o = ad[6:0];
      v = ((o & 'h7e) == 0) ? reloc : ((o & 'h7e) == 2) ? ctrl : 0;
      u_rbrd_host_model.cyc(sn, m, r, w, ad, d, ack, q);
      chk(ack, h);
      chk(reg_hit_o, h);
      chk(host_gfx_o, g);
      if (h)
        chk(pin_addr_o, pe);
      if (h && r && ctrl[4])
        chk(q, v);
      if (h && r && !ctrl[4])
        chk(q[7:0], o[0] ? (v >> 8) & 'hff : v & 'hff);
      if (h && w && ctrl[4] && !o[0])
        commit(o, d);
      else if (h && w && !ctrl[4] && !o[0])
      begin
        held_q.delete();
        held_q.push_back(o);
        held_q.push_back(d[7:0]);
      end
      else if (h && w && !ctrl[4])
      begin
        if (held_q.size() == 2 && held_q[0] == o - 1)
          commit(o - 1, {d[7:0], 8'(held_q[1])});
        held_q.delete();
      end
    end
  endtask : host

  // Whole-register write: byte pair or one word
  task automatic wreg(input logic m, input logic [21:0] ad,
                      input logic [15:0] d);
    begin
      if (ctrl[4])
        host(1'b0, m, 1'b0, 1'b1, ad, d);
      else
      begin
        host(1'b0, m, 1'b0, 1'b1, ad, {8'h00, d[7:0]});
        host(1'b0, m, 1'b0, 1'b1, ad | 22'h1, {8'h00, d[15:8]});
      end
    end
  endtask : wreg

  // Watchdog at 5000 cycles, far beyond the roughly 150 the tests take
  initial
  begin
    #(5000 * 4);
    n_errors++;
    conclude();
  end

  // ============================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h4e8021d8));
    repeat (10) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    chk(word_mode_o, 1'b0);
    chk(relocated_o, 1'b0);
    $display("test reset done");
    repeat (4)
    begin
      a = 22'($urandom);
      host(1'b0, 1'b0, 1'b1, 1'b0, a, 16'h0);
      host(1'b0, 1'b1, 1'b1, 1'b0, a, 16'h0);
      host(1'b1, 1'b0, 1'b0, 1'b1, a, 16'($urandom));
    end
    $display("test unplaced done");
    a = 22'($urandom) & 22'h3fff80;
    wreg(1'b0, a, 16'h03f8);
    @(posedge core_clk_i);
    #1;
    chk(relocated_o, 1'b1);
    chk(mem_space_o, 1'b0);
    for (int i = 0; i < 4; i++)
      host(1'b0, 1'b0, 1'b1, 1'b0, {6'($urandom), 16'hfe00} | 22'(i),
           16'h0);
    host(1'b0, 1'b0, 1'b1, 1'b0, 22'h00fd80, 16'h0);
    host(1'b0, 1'b0, 1'b1, 1'b0, 22'h00fe80, 16'h0);
    wreg(1'b0, 22'h00fe10, 16'h5a5a);
    host(1'b0, 1'b0, 1'b1, 1'b0, 22'h00fe10, 16'h0);
    wreg(1'b0, 22'h00fe12, 16'h0000);
    host(1'b0, 1'b0, 1'b0, 1'b1, 22'h00fe01, 16'h00ff);
    host(1'b0, 1'b0, 1'b1, 1'b0, 22'h00fe01, 16'h0);
    $display("test io block done");
    host(1'b0, 1'b0, 1'b0, 1'b1, 22'h00fe02, 16'h00ef);
    wreg(1'b0, 22'h00fe02, 16'h0010);
    chk(word_mode_o, 1'b1);
    wreg(1'b0, 22'h00fe00, 16'h0041);
    @(posedge core_clk_i);
    #1;
    chk(mem_space_o, 1'b1);
    host(1'b0, 1'b1, 1'b1, 1'b0, 22'h001000, 16'h0);
    host(1'b0, 1'b1, 1'b1, 1'b0, 22'h001002, 16'h0);
    host(1'b0, 1'b1, 1'b0, 1'b1, 22'h001001, 16'hffff);
    host(1'b0, 1'b1, 1'b1, 1'b0, 22'h001000, 16'h0);
    host(1'b0, 1'b0, 1'b1, 1'b0, 22'h00fe00, 16'h0);
    host(1'b0, 1'b1, 1'b0, 1'b1, 22'h002000, 16'h1234);
    gfx_size = 23'h001000;
    host(1'b0, 1'b1, 1'b1, 1'b0, 22'h003000, 16'h0);
    repeat (4)
      host(1'b0, 1'b1, 1'b1, 1'b0, {15'h0020, 7'($urandom)} & 22'h3ffffe,
           16'h0);
    $display("test memory block done");
    // Mid-run reset must drop word mode and the relocation
    @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    reloc = 0;
    ctrl = 0;
    placed = 0;
    held_q.delete();
    chk(word_mode_o, 1'b0);
    chk(relocated_o, 1'b0);
    chk(mem_space_o, 1'b0);
    host(1'b0, 1'b0, 1'b1, 1'b0, 22'($urandom), 16'h0);
    $display("test mid-run reset done");
    for (int i = 0; i < 24; i++)
    begin
      @(posedge core_clk_i);
      #1;
      eng_addr = (i == 0) ? 22'h3fffff : 22'($urandom);
      gfx_size = (i == 0) ? GFX_FULL : 23'($urandom_range(0, 23'h400000));
      il = 1'($urandom);
      fp = 1'($urandom);
      req = 4'($urandom);
      @(posedge core_clk_i);
      #1;
      chk(eng_gfx_o, {1'b0, eng_addr} < gfx_size);
      chk(eng_sys_o, {1'b0, eng_addr} >= gfx_size);
      chk(rate_o, ({1'b0, eng_addr} >= gfx_size) ? 0 : (il && fp) ? 2 :
          (il || fp) ? 1 : 0);
      chk(req_o, req);
    end
    $display("test engine decode done");
    conclude();
  end
endmodule : tb
`default_nettype wire

// file: verilog/rbrd_pkg.sv
// Constants and carrier types for the register block relocation decoder
package rbrd_pkg;

  // ==========================================================================
  // Address geometry
  localparam int unsigned ADDR_W      = 22;  // Device address range, 4 MB
  localparam int unsigned OFF_W       = 7;   // 128-byte register block
  localparam int unsigned SIZE_W      = 23;  // Graphics size, 0 up to 4 MB
  localparam int unsigned DATA_W      = 16;  // Every register is 16 bits
  localparam logic [SIZE_W-1:0] GFX_FULL = 23'h400000;  // Whole range

  // ==========================================================================
  // Register block layout (offsets inside the 128-byte block)
  localparam logic [OFF_W-1:0] REG_RELOC_OFF = 7'h00;  // Relocation register
  localparam logic [OFF_W-1:0] REG_CTRL_OFF  = 7'h02;  // Control register
  localparam int unsigned RELOC_MEM_BIT  = 0;   // Memory space select
  localparam int unsigned CTRL_WORD_BIT  = 4;   // Word access select
  localparam logic [DATA_W-1:0] RELOC_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] RESERVED_RD = 16'h0000;  // Reserved reads

  // ==========================================================================
  // Types
  typedef struct packed {
    logic              sel_n;  // Chip select, active low
    logic              mem;    // 1 memory cycle, 0 I/O cycle
    logic              rd;     // Read strobe, one cycle
    logic              wr;     // Write strobe, one cycle
    logic [ADDR_W-1:0] addr;   // Host address
    logic [DATA_W-1:0] wdata;  // Write data, bytes on [7:0]
  } rbrd_host_t;

  typedef struct packed {
    logic draw;     // Drawing engine
    logic disp;     // Display engine
    logic host;     // External bus master
    logic refresh;  // Memory refresh logic
  } rbrd_req_t;

  typedef enum logic [1:0] {
    RBRD_RATE_10,
    RBRD_RATE_20,
    RBRD_RATE_40
  } rbrd_rate_t;

  typedef enum logic {
    RBRD_PAIR_IDLE,
    RBRD_PAIR_HELD
  } rbrd_pair_t;

endpackage : rbrd_pkg

// file: verilog/rbrd_top.sv
// Register block relocation decoder of the bus interface unit
`timescale 1ns/1ps
`default_nettype none

module rbrd_top (
  input  wire logic                        core_clk_i,   // 250 MHz clock
  input  wire logic                        rst_n_i,      // Sync reset, low
  input  wire rbrd_pkg::rbrd_host_t        host_i,       // Host slave cycle
  input  wire logic [rbrd_pkg::SIZE_W-1:0] gfx_size_i,   // Graphics bytes
  input  wire logic [rbrd_pkg::ADDR_W-1:0] eng_addr_i,   // Engine address
  input  wire logic                        interleave_i, // Interleaved DRAM
  input  wire logic                        fast_page_i,  // Fast page mode
  input  wire rbrd_pkg::rbrd_req_t         req_i,        // Request sources
  output logic                             ack_o,        // Cycle claimed
  output logic [rbrd_pkg::DATA_W-1:0]      rdata_o,      // Read data
  output logic                             reg_hit_o,    // Register access
  output logic                             host_gfx_o,   // Host to gfx mem
  output logic [rbrd_pkg::ADDR_W-1:0]      pin_addr_o,   // Address pins
  output logic                             word_mode_o,  // Word access
  output logic                             mem_space_o,  // Block in memory
  output logic                             relocated_o,  // Base written
  output logic                             eng_gfx_o,    // Engine to gfx
  output logic                             eng_sys_o,    // Engine to system
  output rbrd_pkg::rbrd_req_t              req_o,        // Latched requests
  output rbrd_pkg::rbrd_rate_t             rate_o        // Transfer rate
);
  import rbrd_pkg::*;

  // ==========================================================================
  // Decode functions
  // Block match; the I/O compare drops the upper six base bits
  function automatic logic blk_hit(input logic [ADDR_W-1:0] addr,
                                   input logic              mem,
                                   input logic [DATA_W-1:0] reloc,
                                   input logic              placed);
    if (!placed)
      return !mem;
    if (mem != reloc[RELOC_MEM_BIT])
      return 1'b0;
    if (mem)
      return addr[ADDR_W-1:OFF_W] == reloc[DATA_W-1:1];
    return addr[15:OFF_W] == reloc[9:1];  // I/O space is only 64K
  endfunction : blk_hit

  // Graphics memory spans zero up to the configured size
  function automatic logic in_gfx(input logic [ADDR_W-1:0] addr,
                                  input logic [SIZE_W-1:0] size);
    return ({1'b0, addr} < size);
  endfunction : in_gfx

  // ==========================================================================
  // State
  logic [DATA_W-1:0] reloc_r;
  logic [DATA_W-1:0] ctrl_r;
  logic              placed_r;
  rbrd_pair_t        pair_r;
  logic [7:0]        lo_byte_r;
  logic [OFF_W-1:0]  pair_off_r;

  // ==========================================================================
  // Host cycle decode
  logic              strobe_c;
  logic              claim_c;
  logic [OFF_W-1:0]  off_c;
  logic              word_c;
  logic              commit_c;
  logic [DATA_W-1:0] commit_data_c;
  logic [DATA_W-1:0] word_rd_c;

  assign strobe_c = !host_i.sel_n && (host_i.rd || host_i.wr);
  // Chip select gates everything; outside cycles are never claimed
  assign claim_c  = strobe_c && blk_hit(host_i.addr, host_i.mem, reloc_r,
                                        placed_r);
  assign off_c    = host_i.addr[OFF_W-1:0];
  assign word_c   = ctrl_r[CTRL_WORD_BIT];

  // Writes land as whole words: a word at an even offset, or the odd
  // byte completing a held even byte. A lone odd byte is dropped so a
  // register never sees a half-updated value mid-pair.
  always_comb
  begin
    commit_c      = 1'b0;
    commit_data_c = host_i.wdata;
    if (claim_c && host_i.wr)
    begin
      if (word_c)
        commit_c = !off_c[0];
      else if (off_c[0] && pair_r == RBRD_PAIR_HELD &&
               off_c == (pair_off_r | 7'h01))
      begin
        commit_c      = 1'b1;
        commit_data_c = {host_i.wdata[7:0], lo_byte_r};
      end
    end
  end

  // Whole-word read view; reserved offsets read as zero
  always_comb
  begin
    word_rd_c = RESERVED_RD;
    if (off_c[OFF_W-1:1] == REG_RELOC_OFF[OFF_W-1:1])
      word_rd_c = reloc_r;
    else if (off_c[OFF_W-1:1] == REG_CTRL_OFF[OFF_W-1:1])
      word_rd_c = ctrl_r;
  end

  // ==========================================================================
  // Byte pairing
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      pair_r     <= RBRD_PAIR_IDLE;
      lo_byte_r  <= 8'h00;
      pair_off_r <= 7'h00;
    end
    else if (claim_c && host_i.wr && !word_c)
    begin
      if (!off_c[0])
      begin
        pair_r     <= RBRD_PAIR_HELD;
        lo_byte_r  <= host_i.wdata[7:0];
        pair_off_r <= off_c;
      end
      else
        pair_r <= RBRD_PAIR_IDLE;
    end
  end

  // ==========================================================================
  // Relocation register; writes elsewhere in the block leave it alone
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      reloc_r  <= RELOC_RST;
      placed_r <= 1'b0;
    end
    else if (commit_c && off_c[OFF_W-1:1] == REG_RELOC_OFF[OFF_W-1:1])
    begin
      reloc_r  <= commit_data_c;
      placed_r <= 1'b1;
    end
  end

  // Control register; only the word access select bit is kept here
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      ctrl_r <= CTRL_RST;
    else if (commit_c && off_c[OFF_W-1:1] == REG_CTRL_OFF[OFF_W-1:1])
      ctrl_r[CTRL_WORD_BIT] <= commit_data_c[CTRL_WORD_BIT];
  end

  // ==========================================================================
  // Host answer and address pins
  // Reserved locations still get an acknowledge so the bus never hangs
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ack_o      <= 1'b0;
      reg_hit_o  <= 1'b0;
      rdata_o    <= 16'h0000;
      pin_addr_o <= 22'h000000;
    end
    else
    begin
      ack_o     <= claim_c;
      reg_hit_o <= claim_c;
      if (claim_c && host_i.rd)
      begin
        if (word_c)
          rdata_o <= word_rd_c;
        else if (off_c[0])
          rdata_o <= {8'h00, word_rd_c[15:8]};
        else
          rdata_o <= {8'h00, word_rd_c[7:0]};
      end
      if (claim_c)
        pin_addr_o <= {reloc_r[DATA_W-1:1], off_c};
    end
  end

  // Host memory cycles: registers win on overlap, system memory is never
  // served through this device
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      host_gfx_o <= 1'b0;
    else
      host_gfx_o <= strobe_c && host_i.mem && !claim_c &&
                    in_gfx(host_i.addr, gfx_size_i);
  end

  // Mode outputs mirror the programmed bits
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      word_mode_o <= 1'b0;
      mem_space_o <= 1'b0;
      relocated_o <= 1'b0;
    end
    else
    begin
      word_mode_o <= (commit_c &&
                      off_c[OFF_W-1:1] == REG_CTRL_OFF[OFF_W-1:1]) ?
                     commit_data_c[CTRL_WORD_BIT] : word_c;
      mem_space_o <= reloc_r[RELOC_MEM_BIT];
      relocated_o <= placed_r;
    end
  end

  // ==========================================================================
  // Engine side: register overlap is ignored, engines always hit memory
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      eng_gfx_o <= 1'b0;
      eng_sys_o <= 1'b0;
    end
    else
    begin
      eng_gfx_o <= in_gfx(eng_addr_i, gfx_size_i);
      eng_sys_o <= !in_gfx(eng_addr_i, gfx_size_i);
    end
  end

  // Request sources and rate pick; system memory limits to the slow rate
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      req_o  <= '0;
      rate_o <= RBRD_RATE_10;
    end
    else
    begin
      req_o <= req_i;
      if (!in_gfx(eng_addr_i, gfx_size_i))
        rate_o <= RBRD_RATE_10;
      else if (interleave_i && fast_page_i)
        rate_o <= RBRD_RATE_40;
      else if (interleave_i || fast_page_i)
        rate_o <= RBRD_RATE_20;
      else
        rate_o <= RBRD_RATE_10;
    end
  end

  // ==========================================================================
  // Assertions
  property p_claim_ack;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    claim_c |-> ##1 (ack_o && reg_hit_o);
  endproperty
  a_claim_ack: assert property (p_claim_ack)
    else $error("claimed cycle not acknowledged");
  property p_no_select;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    host_i.sel_n |-> ##1 (!ack_o && $stable(reloc_r) && $stable(ctrl_r));
  endproperty
  a_no_select: assert property (p_no_select)
    else $error("unselected cycle claimed or changed a register");
  property p_reset_byte;
    @(posedge core_clk_i)
    !rst_n_i ##1 rst_n_i |-> (!word_mode_o && !word_c);
  endproperty
  a_reset_byte: assert property (p_reset_byte)
    else $error("word mode set after reset");
  property p_unplaced_io;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (!placed_r && strobe_c && !host_i.mem) |-> ##1 ack_o;
  endproperty
  a_unplaced_io: assert property (p_unplaced_io)
    else $error("unrelocated I/O cycle not claimed");
  property p_mem_miss;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (placed_r && strobe_c &&
     (host_i.mem != reloc_r[RELOC_MEM_BIT] ||
      (host_i.mem && host_i.addr[ADDR_W-1:OFF_W] != reloc_r[DATA_W-1:1])))
    |-> ##1 !ack_o;
  endproperty
  a_mem_miss: assert property (p_mem_miss)
    else $error("cycle outside programmed block claimed");
  property p_io_high_ignored;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (placed_r && !reloc_r[RELOC_MEM_BIT] && strobe_c && !host_i.mem &&
     host_i.addr[15:OFF_W] == reloc_r[9:1]) |-> ##1 ack_o;
  endproperty
  a_io_high_ignored: assert property (p_io_high_ignored)
    else $error("I/O decode looked at high address bits");
  property p_reserved_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (claim_c && host_i.wr && off_c[OFF_W-1:1] != REG_RELOC_OFF[OFF_W-1:1] &&
     off_c[OFF_W-1:1] != REG_CTRL_OFF[OFF_W-1:1])
    |-> ##1 (ack_o && $stable(reloc_r) && $stable(ctrl_r));
  endproperty
  a_reserved_write: assert property (p_reserved_write)
    else $error("reserved write altered a register");
  property p_pin_addr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    claim_c |-> ##1 (pin_addr_o[ADDR_W-1:OFF_W] == $past(reloc_r[15:1]));
  endproperty
  a_pin_addr: assert property (p_pin_addr)
    else $error("address pins not from relocation value");
  property p_eng_split;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ({1'b0, eng_addr_i} < gfx_size_i) |-> ##1 (eng_gfx_o && !eng_sys_o);
  endproperty
  a_eng_split: assert property (p_eng_split)
    else $error("graphics address sent to system memory");
  property p_full_gfx;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (gfx_size_i == GFX_FULL) |-> ##1 !eng_sys_o;
  endproperty
  a_full_gfx: assert property (p_full_gfx)
    else $error("system memory reached with full graphics size");
  property p_req_sources;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    1'b1 |-> ##1 (req_o == $past(req_i));
  endproperty
  a_req_sources: assert property (p_req_sources)
    else $error("request sources not latched");
  property p_rate_fast;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (interleave_i && fast_page_i && {1'b0, eng_addr_i} < gfx_size_i)
    |-> ##1 (rate_o == RBRD_RATE_40);
  endproperty
  a_rate_fast: assert property (p_rate_fast)
    else $error("highest rate not chosen");

  c_relocate: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !placed_r ##1 placed_r);
  c_overlap: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    claim_c && host_i.mem && in_gfx(host_i.addr, gfx_size_i));
  c_byte_pair: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    commit_c && !word_c);

endmodule : rbrd_top

`default_nettype wire
